// ---- src/apbc_pkg.sv ----
// constants, field layout and types of the autopoll/bitcheck control block
package apbc_pkg;
    // clock and time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_US = 1000;
    localparam int SLEEP_BASE_MS = 10;
    localparam int WDOG_FAST_MS = 5;
    localparam int WDOG_MID_MS = 10;
    localparam int WDOG_SLOW_MS = 20;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;

    // control word fields
    localparam int CTRL_W = 21;
    localparam int BW_LSB = 3;
    localparam int SLICE_LSB = 5;
    localparam int BITCNT_LSB = 7;
    localparam int WIN_LSB = 9;
    localparam int SLEEP_LSB = 12;
    localparam int AUTOPOLL_BIT = 15;
    localparam int WDOG_DIS_BIT = 18;
    localparam int BW_SRC_BIT = 20;
    localparam logic [1:0] BW_RESET = 2'h3;
    localparam logic [1:0] SLICE_RESET = 2'h3;
    // window code 111 out of reset: the shortest, least strict window
    localparam logic [20:0] CTRL_RESET = 21'h0_0e78;

    // status word fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_GOOD_LSB = 4;
    localparam int STAT_BW_LSB = 12;

    // minimum edge interval in us, [window code][bandwidth column]
    localparam logic [9:0] WIN_US [8][4] = '{
        '{10'd67, 10'd136, 10'd270, 10'd541},
        '{10'd64, 10'd126, 10'd252, 10'd505},
        '{10'd59, 10'd118, 10'd234, 10'd469},
        '{10'd54, 10'd108, 10'd216, 10'd434},
        '{10'd49, 10'd100, 10'd198, 10'd397},
        '{10'd45, 10'd90, 10'd180, 10'd361},
        '{10'd41, 10'd82, 10'd163, 10'd325},
        '{10'd36, 10'd72, 10'd144, 10'd289}};

    typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_CHECK} apbc_state_t;
endpackage

// ---- src/apbc_autopoll.sv ----
// autopoll sleep timer, bitcheck and receiver control word
module apbc_autopoll #(
    parameter int SLEEP_TICKS_10MS = 10,
    parameter int MS_US_P = apbc_pkg::MS_US
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // register port
    input wire logic [apbc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [apbc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [apbc_pkg::DATA_W-1:0] reg_rdata,
    // pins and analog-side signals
    input wire logic bw_select_pin_low,
    input wire logic bw_select_pin_high,
    input wire logic sleep_osc,
    input wire logic rx_data,
    // outputs
    output logic data_out,
    output logic rx_powered,
    output logic [1:0] bw_code,
    output logic [1:0] slice_code
);
    if (SLEEP_TICKS_10MS < 1 || SLEEP_TICKS_10MS > 511) begin : g_chk_sleep
        $error("SLEEP_TICKS_10MS out of range 1..511");
    end
    if (MS_US_P < 1 || MS_US_P > 65535) begin : g_chk_ms
        $error("MS_US_P out of range 1..65535");
    end

    typedef struct packed {
        logic [apbc_pkg::CTRL_W-1:0] ctrl;
        apbc_pkg::apbc_state_t state;
        logic osc_prev;
        logic rx_prev;
        logic [6:0] us_cnt;
        logic [15:0] ms_cnt;
        logic [15:0] sleep_cnt;
        logic [4:0] wdog_cnt;
        logic [9:0] ivl_us;
        logic seen_edge;
        logic [4:0] good_cnt;
        logic [apbc_pkg::DATA_W-1:0] rdata;
        logic data_out;
        logic rx_powered;
        logic [1:0] bw_code;
        logic [1:0] slice_code;
    } apbc_regs_t;

    localparam apbc_regs_t S_RESET = '{
        ctrl: apbc_pkg::CTRL_RESET,
        state: apbc_pkg::ST_AWAKE,
        bw_code: apbc_pkg::BW_RESET,
        slice_code: apbc_pkg::SLICE_RESET,
        default: '0};

    logic rst_meta;
    logic rst_sync;
    apbc_regs_t s;
    apbc_regs_t n;

    logic ctrl_wr;
    logic ap_set;
    logic ap_clr;
    logic us_tick;
    logic ms_tick;
    logic osc_rise;
    logic rx_edge;
    logic wdog_dis;
    logic [1:0] bw_eff;
    logic [1:0] win_col;
    logic [9:0] win_us;
    logic [4:0] need;
    logic [4:0] wdog_need;
    logic [15:0] sleep_need;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    always_comb begin
        ctrl_wr = reg_wr && reg_addr == apbc_pkg::CTRL_OFS;
        // a write of one over one does not restart sleep: only 0 then 1
        ap_set = ctrl_wr && reg_wdata[apbc_pkg::AUTOPOLL_BIT]
            && !s.ctrl[apbc_pkg::AUTOPOLL_BIT];
        ap_clr = ctrl_wr && !reg_wdata[apbc_pkg::AUTOPOLL_BIT];
        us_tick = s.us_cnt == 7'(apbc_pkg::US_CYCLES - 1);
        ms_tick = us_tick && s.ms_cnt == 16'(MS_US_P - 1);
        osc_rise = sleep_osc && !s.osc_prev;
        rx_edge = rx_data != s.rx_prev;
        wdog_dis = s.ctrl[apbc_pkg::WDOG_DIS_BIT];
        // pads pull the select pins high, so floating reads as 11
        bw_eff = s.ctrl[apbc_pkg::BW_SRC_BIT]
            ? s.ctrl[apbc_pkg::BW_LSB +: 2]
            : {bw_select_pin_high, bw_select_pin_low};
        // narrower bandwidth, slower data: later columns hold longer windows
        win_col = ~bw_eff;
        win_us = apbc_pkg::WIN_US[s.ctrl[apbc_pkg::WIN_LSB +: 3]][win_col];
        // two periods, high and low, make one bit
        // field bit 1 is the first digit of the printed codes
        unique case (s.ctrl[apbc_pkg::BITCNT_LSB +: 2])
            2'b00: need = 5'd0;
            2'b01: need = 5'd4;
            2'b10: need = 5'd8;
            2'b11: need = 5'd16;
        endcase
        unique case (bw_eff)
            2'b11, 2'b10: wdog_need = 5'(apbc_pkg::WDOG_FAST_MS);
            2'b01: wdog_need = 5'(apbc_pkg::WDOG_MID_MS);
            2'b00: wdog_need = 5'(apbc_pkg::WDOG_SLOW_MS);
        endcase
        sleep_need = 16'(SLEEP_TICKS_10MS)
            << s.ctrl[apbc_pkg::SLEEP_LSB +: 3];
    end

    always_comb begin
        n = s;
        n.osc_prev = sleep_osc;
        n.rx_prev = rx_data;
        n.us_cnt = us_tick ? 7'd0 : s.us_cnt + 7'd1;
        if (us_tick) begin
            n.ms_cnt = ms_tick ? 16'd0 : s.ms_cnt + 16'd1;
        end
        if (ctrl_wr) begin
            n.ctrl = reg_wdata[apbc_pkg::CTRL_W-1:0];
        end
        unique case (s.state)
            apbc_pkg::ST_AWAKE: begin
            end
            apbc_pkg::ST_SLEEP: begin
                if (osc_rise) begin
                    if (s.sleep_cnt >= sleep_need - 16'd1) begin
                        n.sleep_cnt = 16'd0;
                        n.state = need == 5'd0 ? apbc_pkg::ST_AWAKE
                            : apbc_pkg::ST_CHECK;
                        n.us_cnt = 7'd0;
                        n.ms_cnt = 16'd0;
                        n.wdog_cnt = 5'd0;
                        n.ivl_us = 10'd0;
                        n.seen_edge = 1'b0;
                        n.good_cnt = 5'd0;
                    end else begin
                        n.sleep_cnt = s.sleep_cnt + 16'd1;
                    end
                end
            end
            apbc_pkg::ST_CHECK: begin
                if (rx_edge) begin
                    n.us_cnt = 7'd0;
                    n.ms_cnt = 16'd0;
                    n.wdog_cnt = 5'd0;
                    n.ivl_us = 10'd0;
                    n.seen_edge = 1'b1;
                    // first edge only opens the first period
                    if (s.seen_edge) begin
                        if (s.ivl_us < win_us) begin
                            n.state = apbc_pkg::ST_SLEEP;
                        end else if (s.good_cnt + 5'd1 == need) begin
                            n.state = apbc_pkg::ST_AWAKE;
                        end else begin
                            n.good_cnt = s.good_cnt + 5'd1;
                        end
                    end
                end else begin
                    if (us_tick && s.ivl_us != 10'h3ff) begin
                        n.ivl_us = s.ivl_us + 10'd1;
                    end
                    if (ms_tick && !wdog_dis) begin
                        if (s.wdog_cnt + 5'd1 >= wdog_need) begin
                            n.state = apbc_pkg::ST_SLEEP;
                        end else begin
                            n.wdog_cnt = s.wdog_cnt + 5'd1;
                        end
                    end
                end
            end
        endcase
        if (ap_clr) begin
            n.state = apbc_pkg::ST_AWAKE;
        end else if (ap_set) begin
            n.state = apbc_pkg::ST_SLEEP;
            n.sleep_cnt = 16'd0;
        end
        n.rdata = '0;
        if (reg_rd && reg_addr == apbc_pkg::CTRL_OFS) begin
            n.rdata[apbc_pkg::CTRL_W-1:0] = s.ctrl;
        end else if (reg_rd && reg_addr == apbc_pkg::STAT_OFS) begin
            n.rdata[apbc_pkg::STAT_STATE_LSB +: 2] = s.state;
            n.rdata[apbc_pkg::STAT_GOOD_LSB +: 5] = s.good_cnt;
            n.rdata[apbc_pkg::STAT_BW_LSB +: 2] = bw_eff;
        end
        n.data_out = s.state == apbc_pkg::ST_AWAKE && rx_data;
        n.rx_powered = s.state != apbc_pkg::ST_SLEEP;
        n.bw_code = bw_eff;
        n.slice_code = s.ctrl[apbc_pkg::SLICE_LSB +: 2];
    end

    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s <= S_RESET;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata = s.rdata;
    assign data_out = s.data_out;
    assign rx_powered = s.rx_powered;
    assign bw_code = s.bw_code;
    assign slice_code = s.slice_code;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_sync);

    sequence s_bad_edge;
        s.state == apbc_pkg::ST_CHECK && rx_edge && s.seen_edge
            && s.ivl_us < win_us && !ctrl_wr;
    endsequence

    sequence s_last_good;
        s.state == apbc_pkg::ST_CHECK && rx_edge && s.seen_edge
            && s.ivl_us >= win_us && s.good_cnt + 5'd1 == need && !ctrl_wr;
    endsequence

    a_data_gated: assert property (
        s.state != apbc_pkg::ST_AWAKE |=> !data_out)
        else $error("data out not held low outside awake");
    a_sleep_start: assert property (
        ap_set |=> s.state == apbc_pkg::ST_SLEEP ##1 !rx_powered)
        else $error("enable edge did not start sleep");
    a_awake_holds: assert property (
        s.state == apbc_pkg::ST_AWAKE && !ctrl_wr
            |=> s.state == apbc_pkg::ST_AWAKE)
        else $error("left awake without a command");
    a_bad_sleeps: assert property (
        s_bad_edge |=> s.state == apbc_pkg::ST_SLEEP)
        else $error("bad period did not return to sleep");
    a_good_wakes: assert property (
        s_last_good |=> s.state == apbc_pkg::ST_AWAKE
            ##1 data_out == $past(rx_data))
        else $error("enough good periods did not release data");
    a_wdog_fires: assert property (
        s.state == apbc_pkg::ST_CHECK && ms_tick && !wdog_dis && !rx_edge
            && s.wdog_cnt + 5'd1 >= wdog_need && !ctrl_wr
            |=> s.state == apbc_pkg::ST_SLEEP)
        else $error("watchdog expiry did not return to sleep");
    a_wdog_off: assert property (
        s.state == apbc_pkg::ST_CHECK && wdog_dis && !rx_edge && !ctrl_wr
            |=> s.state == apbc_pkg::ST_CHECK)
        else $error("disabled watchdog ended the check");
    a_zero_bits: assert property (
        s.state == apbc_pkg::ST_SLEEP && osc_rise && need == 5'd0 && !ctrl_wr
            && s.sleep_cnt >= sleep_need - 16'd1
            |=> s.state == apbc_pkg::ST_AWAKE)
        else $error("zero bitcount did not wake directly");
    a_bw_pins: assert property (
        !s.ctrl[apbc_pkg::BW_SRC_BIT]
            |=> bw_code == $past({bw_select_pin_high, bw_select_pin_low}))
        else $error("bandwidth code does not follow pins");
    a_slice_hold: assert property (
        !ctrl_wr ##1 !ctrl_wr |=> $stable(slice_code))
        else $error("slice code changed without a write");
    a_sleep_unpowered: assert property (
        s.state == apbc_pkg::ST_SLEEP |=> !rx_powered)
        else $error("receiver powered while asleep");
    a_data_follows: assert property (
        s.state == apbc_pkg::ST_AWAKE |=> data_out == $past(rx_data))
        else $error("data out does not follow data while awake");
    a_bw_serial: assert property (
        s.ctrl[apbc_pkg::BW_SRC_BIT]
            |=> bw_code == $past(s.ctrl[apbc_pkg::BW_LSB +: 2]))
        else $error("bandwidth code does not follow serial bits");
    a_slice_write: assert property (
        ctrl_wr |=> ##1 slice_code
            == $past(reg_wdata[apbc_pkg::SLICE_LSB +: 2], 2))
        else $error("slice code does not take the written value");
endmodule

// ---- verification/apbc_partner.sv ----
// far-side model: free sleep oscillator and return-to-zero data source
module apbc_partner (
    // clock
    input wire logic ref_clk,
    // bench control
    input wire logic run,
    input wire logic [31:0] half_cyc,
    // far-side signals
    output logic sleep_osc,
    output logic rx_data,
    output logic [7:0] n_edge
);
    timeunit 1ns;
    timeprecision 1ps;
    int osc_cnt = 0;
    int bit_cnt = 0;
    initial begin
        sleep_osc = 1'b0;
        rx_data = 1'b0;
        n_edge = 8'h00;
    end
    // slow and free running, unrelated to traffic
    always @(posedge ref_clk) begin
        osc_cnt <= (osc_cnt == 399) ? 0 : osc_cnt + 1;
        sleep_osc <= (osc_cnt < 200);
    end
    // equal high and low halves, two periods per bit
    always @(posedge ref_clk) begin
        if (!run) begin
            bit_cnt <= 0;
            rx_data <= 1'b0;
            n_edge <= 8'h00;
        end else if (bit_cnt == half_cyc - 1) begin
            bit_cnt <= 0;
            rx_data <= !rx_data;
            n_edge <= n_edge + 8'h01;
        end else begin
            bit_cnt <= bit_cnt + 1;
        end
    end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the autopoll and bitcheck control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, rdv;
    logic bw_select_pin_low = 1'b1;
    logic bw_select_pin_high = 1'b1;
    logic run = 1'b0;
    logic sleep_osc, rx_data, data_out, rx_powered;
    logic [1:0] bw_code, slice_code;
    logic [7:0] n_edge;
    int half_cyc = 5000;
    int n_mismatch = 0;
    int compares = 0;

    // short counts: one tick per sleep unit, 20 us per watchdog ms
    apbc_autopoll #(.SLEEP_TICKS_10MS(1), .MS_US_P(20)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bw_select_pin_low(bw_select_pin_low),
        .bw_select_pin_high(bw_select_pin_high), .sleep_osc(sleep_osc),
        .rx_data(rx_data), .data_out(data_out), .rx_powered(rx_powered),
        .bw_code(bw_code), .slice_code(slice_code));
    apbc_partner peer (
        .ref_clk(ref_clk), .run(run), .half_cyc(half_cyc),
        .sleep_osc(sleep_osc), .rx_data(rx_data), .n_edge(n_edge));

    always #5 ref_clk = ~ref_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wait_pw(input logic lvl, input int lim);
        int i;
        i = 0;
        #1;
        while (i < lim && rx_powered !== lvl) begin
            @(posedge ref_clk);
            #1;
            i++;
        end
        chk(32'(rx_powered), 32'(lvl));
    endtask
    // serial bandwidth source always chosen here
    function automatic logic [31:0] ctl(input logic [1:0] bw, sl, bc,
        input logic [2:0] win, slp, input logic ap, wd);
        ctl = {11'h0, 1'b1, 1'b0, wd, 2'b00, ap, slp, win, bc, sl, bw, 3'h0};
    endfunction
    // sleep is restarted only by a low-then-high enable write
    task automatic arm(input logic [31:0] c, input logic go);
        wr(4'h0, c & 32'hffff_7fff);
        wr(4'h0, c);
        wait_pw(1'b0, 5);
        wait_pw(1'b1, 1700);
        @(posedge ref_clk);
        run <= go;
    endtask

    task automatic t_reset();
        chk(32'(bw_code), 32'h3);
        chk(32'(slice_code), 32'h3);
        rd(4'h0);
        chk(rdv, 32'h0000_0e78);
        wr(4'h8, 32'hffff_ffff);
        rd(4'h8);
        chk(rdv, 32'h0000_0000);
        rd(4'h0);
        chk(rdv, 32'h0000_0e78);
    endtask
    task automatic t_codes();
        for (int k = 0; k < 4; k++) begin
            wr(4'h0, ctl(2'(k), 2'(3 - k), 2'h0, 3'h0, 3'h0, 1'b0, 1'b0));
            settle(2);
            chk(32'(bw_code), 32'(k));
            chk(32'(slice_code), 32'(3 - k));
            @(posedge ref_clk);
            bw_select_pin_low <= k[0];
            bw_select_pin_high <= k[1];
            wr(4'h0, ctl(2'(3 - k), 2'h3, 2'h0, 3'h0, 3'h0, 1'b0, 1'b0)
                ^ 32'h0010_0000);
            settle(3);
            chk(32'(bw_code), 32'(k));
        end
    endtask
    task automatic t_simple();
        arm(ctl(2'h3, 2'h3, 2'h0, 3'h0, 3'h2, 1'b1, 1'b0), 1'b0);
        wr(4'h0, ctl(2'h3, 2'h3, 2'h0, 3'h0, 3'h2, 1'b0, 1'b0));
        wr(4'h0, ctl(2'h3, 2'h3, 2'h0, 3'h0, 3'h2, 1'b1, 1'b0));
        settle(1000);
        chk(32'(rx_powered), 32'h0);
        wait_pw(1'b1, 1300);
        rd(4'h4);
        chk(rdv & 32'h3, 32'(apbc_pkg::ST_AWAKE));
        wr(4'h0, ctl(2'h3, 2'h3, 2'h0, 3'h0, 3'h2, 1'b1, 1'b0));
        settle(1500);
        chk(32'(rx_powered), 32'h1);
    endtask
    task automatic t_good();
        arm(ctl(2'h3, 2'h3, 2'h1, 3'h7, 3'h0, 1'b1, 1'b0), 1'b1);
        settle(5200);
        chk(32'(data_out), 32'h0);
        for (int i = 0; i < 30000 && data_out !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk(32'(n_edge), 32'h5);
        rd(4'h4);
        chk(rdv & 32'h3003, 32'h3000);
        run <= 1'b0;
    endtask
    task automatic t_bad();
        // same data as above, but a window longer than its halves
        arm(ctl(2'h3, 2'h3, 2'h1, 3'h0, 3'h0, 1'b1, 1'b0), 1'b1);
        wait_pw(1'b0, 10200);
        wait_pw(1'b1, 500);
        chk(32'(data_out), 32'h0);
        @(posedge ref_clk);
        run <= 1'b0;
    endtask
    task automatic t_wdog();
        arm(ctl(2'h3, 2'h3, 2'h1, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
        settle(9000);
        chk(32'(rx_powered), 32'h1);
        wait_pw(1'b0, 2000);
        // code 01 is the 3250 Hz setting: twice the watchdog time
        arm(ctl(2'h1, 2'h3, 2'h1, 3'h0, 3'h0, 1'b1, 1'b0), 1'b0);
        settle(19000);
        chk(32'(rx_powered), 32'h1);
        wait_pw(1'b0, 2000);
        arm(ctl(2'h3, 2'h3, 2'h1, 3'h0, 3'h0, 1'b1, 1'b1), 1'b0);
        settle(12000);
        chk(32'(rx_powered), 32'h1);
    endtask

    task automatic summarize();
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_reset();
        t_codes();
        t_simple();
        t_good();
        t_bad();
        t_wdog();
        summarize();
    end
    // a little above the expected run length of about 85000 cycles
    initial begin
        #950_000;
        n_mismatch++;
        summarize();
    end
endmodule
